// ### sss_top.sv
`timescale 1ns/1ps
`default_nettype none
module sss_top #(
  parameter int IRQ_PULSE_CYCLES = sss_pkg::IRQ_PULSE_CYC,
  parameter int OSC_STALL_CYCLES = sss_pkg::OSC_STALL_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 osc_clk,
  input  wire logic                 osc_rstn,
  input  wire logic                 counter_zero,
  input  wire sss_pkg::sss_bus_in_t bus_in,
  output sss_pkg::sss_od_t          sda_od,
  output sss_pkg::sss_od_t          wave_irq_output,
  output sss_pkg::sss_ctrl_t        ctrl_o
);

  // --------------------------------------------------------------------------
  // State of the oscillator domain
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic zero_tgl;
    logic beat_tgl;
  } sss_osc_state_t;

  // --------------------------------------------------------------------------
  // State of the system domain
  // --------------------------------------------------------------------------
  typedef struct packed {
    sss_pkg::sss_bus_in_t  pin_s1;
    sss_pkg::sss_bus_in_t  pin_s2;
    sss_pkg::sss_bus_in_t  pin_d;
    sss_pkg::sss_i2c_st_t  fsm;
    logic [3:0]            bit_cnt;
    logic [7:0]            rx_sh;
    logic [7:0]            tx_sh;
    logic                  rd_dir;
    logic                  first_wr;
    logic [7:0]            ptr;
    sss_pkg::sss_ctrl_t    ctrl;
    logic                  osc_stop_flag;
    logic                  af;
    logic                  pulse_act;
    logic [25:0]           pulse_cnt;
    logic [2:0]            zero_sync;
    logic [2:0]            beat_sync;
    logic [15:0]           stall_cnt;
    sss_pkg::sss_mem_req_t mem_req;
    sss_pkg::sss_od_t      sda;
    sss_pkg::sss_od_t      irq;
  } sss_sys_state_t;

  sss_osc_state_t osc_r;
  sss_osc_state_t osc_nxt;
  sss_sys_state_t s_r;
  sss_sys_state_t s_nxt;
  logic [7:0]     mem_rdata;

  // Byte presented for a read at the given pointer value
  function automatic logic [7:0] read_byte(
    input logic [7:0]         ptr,
    input logic [7:0]         mem_byte,
    input sss_pkg::sss_ctrl_t ctrl,
    input logic               osc_stop_flag,
    input logic               af
  );
    logic [7:0] v;
    v = 8'h00;
    if (ptr < sss_pkg::OFS_CONTROL)
    begin
      v = mem_byte;
    end
    else if (ptr == sss_pkg::OFS_CONTROL)
    begin
      v = ctrl;
      v[4] = 1'b0;
    end
    else if (ptr == sss_pkg::OFS_STATUS)
    begin
      v[sss_pkg::STAT_OSF_BIT] = osc_stop_flag;
      v[sss_pkg::STAT_AF_BIT] = af;
    end
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // Oscillator domain: event toggle and heartbeat
  // --------------------------------------------------------------------------

  // Zero events become a toggle; the heartbeat lets the system side see a
  // stopped oscillator, which a level from this domain could never report
  always_comb
  begin
    osc_nxt = osc_r;
    osc_nxt.beat_tgl = ~osc_r.beat_tgl;
    if (counter_zero)
    begin
      osc_nxt.zero_tgl = ~osc_r.zero_tgl;
    end
  end

  always_ff @(posedge osc_clk)
  begin
    if (!osc_rstn)
    begin
      osc_r <= '0;
    end
    else
    begin
      osc_r <= osc_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // System domain: pin sampling, protocol engine, flags, interrupt pin
  // --------------------------------------------------------------------------
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       zero_evt;
  logic       osc_stopped;
  logic       wr_stat;
  logic [7:0] tx_next;

  // Conditions derived only from the second synchroniser stage onward
  assign scl_rise   = s_r.pin_s2.scl & ~s_r.pin_d.scl;
  assign scl_fall   = ~s_r.pin_s2.scl & s_r.pin_d.scl;
  assign start_cond = s_r.pin_s2.scl & s_r.pin_d.scl & ~s_r.pin_s2.sda & s_r.pin_d.sda;
  assign stop_cond  = s_r.pin_s2.scl & s_r.pin_d.scl & s_r.pin_s2.sda & ~s_r.pin_d.sda;
  assign zero_evt   = s_r.zero_sync[1] ^ s_r.zero_sync[2];
  assign osc_stopped = (s_r.stall_cnt == 16'(OSC_STALL_CYCLES - 1)) | s_r.ctrl.osc_disable;
  assign tx_next    = read_byte(s_r.ptr, mem_rdata, s_r.ctrl, s_r.osc_stop_flag, s_r.af);

  always_comb
  begin
    s_nxt = s_r;
    wr_stat = 1'b0;
    s_nxt.mem_req.we = 1'b0;

    // Two-stage synchronisers, plus one delayed copy for edge detection
    s_nxt.pin_s1 = bus_in;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_d  = s_r.pin_s2;
    s_nxt.zero_sync = {s_r.zero_sync[1:0], osc_r.zero_tgl};
    s_nxt.beat_sync = {s_r.beat_sync[1:0], osc_r.beat_tgl};

    // Oscillator watchdog: counts while the heartbeat is silent
    if (s_r.beat_sync[1] ^ s_r.beat_sync[2])
    begin
      s_nxt.stall_cnt = '0;
    end
    else if (s_r.stall_cnt != 16'(OSC_STALL_CYCLES - 1))
    begin
      s_nxt.stall_cnt = s_r.stall_cnt + 16'h0001;
    end

    // Bit sampling happens only at SCL rising, while the line is stable
    if (scl_rise)
    begin
      case (s_r.fsm)
        sss_pkg::ST_ADDR, sss_pkg::ST_WRITE:
        begin
          s_nxt.rx_sh   = {s_r.rx_sh[6:0], s_r.pin_s2.sda};
          s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
        end
        sss_pkg::ST_READ:
        begin
          s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
        end
        sss_pkg::ST_MACK:
        begin
          if (s_r.pin_s2.sda)
          begin
            s_nxt.fsm = sss_pkg::ST_IGNORE;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Drive changes only at SCL falling, so SDA never moves while SCL is high
    if (scl_fall)
    begin
      case (s_r.fsm)
        sss_pkg::ST_ADDR:
        begin
          if (s_r.bit_cnt == 4'h8)
          begin
            if (s_r.rx_sh[7:1] == sss_pkg::DEV_ADDR)
            begin
              s_nxt.rd_dir = s_r.rx_sh[0];
              s_nxt.sda.oe = 1'b1;
              s_nxt.fsm    = sss_pkg::ST_ACK;
            end
            else
            begin
              s_nxt.fsm = sss_pkg::ST_IGNORE;
            end
          end
        end
        sss_pkg::ST_WRITE:
        begin
          if (s_r.bit_cnt == 4'h8)
          begin
            if (s_r.first_wr)
            begin
              s_nxt.ptr      = s_r.rx_sh;
              s_nxt.first_wr = 1'b0;
            end
            else
            begin
              s_nxt.ptr = s_r.ptr + 8'h01;
              if (s_r.ptr < sss_pkg::OFS_CONTROL)
              begin
                s_nxt.mem_req.we    = 1'b1;
                s_nxt.mem_req.addr  = s_r.ptr[sss_pkg::MEM_AW-1:0];
                s_nxt.mem_req.wdata = s_r.rx_sh;
              end
              else if (s_r.ptr == sss_pkg::OFS_CONTROL)
              begin
                s_nxt.ctrl = s_r.rx_sh;
                s_nxt.ctrl.unused_zero = 1'b0;
              end
              else if (s_r.ptr == sss_pkg::OFS_STATUS)
              begin
                wr_stat = 1'b1;
              end
            end
            s_nxt.sda.oe = 1'b1;
            s_nxt.fsm    = sss_pkg::ST_ACK;
          end
        end
        sss_pkg::ST_ACK:
        begin
          s_nxt.bit_cnt = 4'h0;
          if (s_r.rd_dir)
          begin
            s_nxt.sda.oe = ~tx_next[7];
            s_nxt.tx_sh  = {tx_next[6:0], 1'b0};
            s_nxt.fsm    = sss_pkg::ST_READ;
          end
          else
          begin
            s_nxt.sda.oe = 1'b0;
            s_nxt.fsm    = sss_pkg::ST_WRITE;
          end
        end
        sss_pkg::ST_READ:
        begin
          if (s_r.bit_cnt == 4'h8)
          begin
            s_nxt.sda.oe = 1'b0;
            s_nxt.ptr    = s_r.ptr + 8'h01;
            s_nxt.fsm    = sss_pkg::ST_MACK;
          end
          else
          begin
            s_nxt.sda.oe = ~s_r.tx_sh[7];
            s_nxt.tx_sh  = {s_r.tx_sh[6:0], 1'b0};
          end
        end
        sss_pkg::ST_MACK:
        begin
          s_nxt.bit_cnt = 4'h0;
          s_nxt.sda.oe  = ~tx_next[7];
          s_nxt.tx_sh   = {tx_next[6:0], 1'b0};
          s_nxt.fsm     = sss_pkg::ST_READ;
        end
        default:
        begin
        end
      endcase
    end

    // Bus conditions override everything; repeated start restarts addressing
    if (start_cond)
    begin
      s_nxt.fsm      = sss_pkg::ST_ADDR;
      s_nxt.bit_cnt  = 4'h0;
      s_nxt.first_wr = 1'b1;
      s_nxt.sda.oe   = 1'b0;
    end
    else if (stop_cond)
    begin
      s_nxt.fsm    = sss_pkg::ST_IDLE;
      s_nxt.sda.oe = 1'b0;
    end

    // Oscillator-stop flag: software may clear it, a live stop wins
    if (wr_stat && !s_r.rx_sh[sss_pkg::STAT_OSF_BIT])
    begin
      s_nxt.osc_stop_flag = 1'b0;
    end
    if (osc_stopped)
    begin
      s_nxt.osc_stop_flag = 1'b1;
    end

    // Watchdog pulse runs to its full length regardless of software writes
    if (s_r.pulse_act)
    begin
      s_nxt.pulse_cnt = s_r.pulse_cnt + 26'h1;
      if (s_r.pulse_cnt == 26'(IRQ_PULSE_CYCLES - 1))
      begin
        s_nxt.pulse_act = 1'b0;
        s_nxt.af        = 1'b0;
      end
    end

    // Alarm flag: write of zero clears, write of one is ignored
    if (wr_stat && !s_r.rx_sh[sss_pkg::STAT_AF_BIT])
    begin
      s_nxt.af = 1'b0;
    end
    if (zero_evt)
    begin
      s_nxt.af = 1'b1;
      if (s_r.ctrl.counter_mode_select && s_r.ctrl.irq_route_select &&
          s_r.ctrl.alarm_irq_enable && !s_r.pulse_act)
      begin
        s_nxt.pulse_act = 1'b1;
        s_nxt.pulse_cnt = '0;
      end
    end

    // Interrupt pin is open drain: low while active, released otherwise
    s_nxt.irq.o  = 1'b0;
    s_nxt.irq.oe = s_nxt.pulse_act |
                   (!s_nxt.ctrl.counter_mode_select && s_nxt.ctrl.irq_route_select &&
                    s_nxt.ctrl.alarm_irq_enable && s_nxt.af);
    s_nxt.sda.o  = 1'b0;
  end

  // Synchronous reset; state stands still while the enable is low
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      s_r          <= '0;
      s_r.pin_s1   <= 2'h3;
      s_r.pin_s2   <= 2'h3;
      s_r.pin_d    <= 2'h3;
      s_r.fsm      <= sss_pkg::ST_IDLE;
      s_r.ctrl     <= sss_pkg::CTRL_RESET;
      s_r.osc_stop_flag      <= sss_pkg::STAT_RESET[sss_pkg::STAT_OSF_BIT];
      s_r.af       <= sss_pkg::STAT_RESET[sss_pkg::STAT_AF_BIT];
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // General register bytes
  // --------------------------------------------------------------------------
  sss_regmem u_regmem (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ce      (ce),
    .req     (s_r.mem_req),
    .rd_addr (s_r.ptr[sss_pkg::MEM_AW-1:0]),
    .rd_data (mem_rdata)
  );

  // --------------------------------------------------------------------------
  // Outputs, all straight from registers
  // --------------------------------------------------------------------------
  assign sda_od          = s_r.sda;
  assign wave_irq_output = s_r.irq;
  assign ctrl_o          = s_r.ctrl;

endmodule
`default_nettype wire

// ### sss_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------------------
package sss_pkg;

  // --------------------------------------------------------------------------
  // Bus address and register map
  // --------------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR    = 7'h68;   // 1101000
  localparam logic [7:0] OFS_CONTROL = 8'h07;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam int         MEM_WORDS   = 8;       // Bytes 00h..06h, one spare
  localparam int         MEM_AW      = 3;

  // --------------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------------
  localparam int         STAT_OSF_BIT = 7;
  localparam int         STAT_AF_BIT  = 0;
  localparam logic [7:0] CTRL_RESET   = 8'h06;
  localparam logic [7:0] STAT_RESET   = 8'h80;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_SYS_KHZ   = 200000;
  localparam int IRQ_PULSE_MS  = 250;
  localparam int IRQ_PULSE_CYC = IRQ_PULSE_MS * CLK_SYS_KHZ;
  localparam int OSC_STALL_US  = 100;
  localparam int OSC_STALL_CYC = (OSC_STALL_US * CLK_SYS_KHZ) / 1000;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       osc_disable;
    logic       counter_enable;
    logic       counter_mode_select;
    logic       unused_zero;
    logic       irq_route_select;
    logic [1:0] rate_select;
    logic       alarm_irq_enable;
  } sss_ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } sss_bus_in_t;

  typedef struct packed {
    logic o;
    logic oe;
  } sss_od_t;

  typedef struct packed {
    logic              we;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        wdata;
  } sss_mem_req_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WRITE,
    ST_READ,
    ST_MACK,
    ST_IGNORE
  } sss_i2c_st_t;

endpackage

// ### sss_regmem.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Byte store for the general registers, registered read port
// ----------------------------------------------------------------------------
module sss_regmem (
  input  wire logic                            clk_sys,
  input  wire logic                            rstn,
  input  wire logic                            ce,
  input  wire sss_pkg::sss_mem_req_t           req,
  input  wire logic [sss_pkg::MEM_AW-1:0]      rd_addr,
  output logic [7:0]                           rd_data
);

  typedef struct packed {
    logic [sss_pkg::MEM_WORDS-1:0][7:0] mem;
    logic [7:0]                         rdata;
  } sss_mem_state_t;

  sss_mem_state_t st_r;
  sss_mem_state_t st_nxt;

  // Write port and read register; read follows the write one cycle later
  always_comb
  begin
    st_nxt = st_r;
    if (req.we)
    begin
      st_nxt.mem[req.addr] = req.wdata;
    end
    st_nxt.rdata = st_r.mem[rd_addr];
  end

  // Contents are undefined at power-up, cleared here for a clean simulation
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rdata;

endmodule
`default_nettype wire

// ### sss_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bus pin and interrupt pin checks
// ------------------------------------------------------------
module sss_chk #(
  parameter int IRQ_PULSE_CYCLES = 4000
) (
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  input wire logic                 counter_zero,
  input wire sss_pkg::sss_bus_in_t bus_in,
  input wire sss_pkg::sss_od_t     sda_od,
  input wire sss_pkg::sss_od_t     wave_irq_output,
  input wire sss_pkg::sss_ctrl_t   ctrl_o
);
  int unsigned low_cnt_r;
  logic        irq_on;
  logic        wdog;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Interrupt path enables
  assign irq_on = ctrl_o.irq_route_select & ctrl_o.alarm_irq_enable;
  assign wdog   = irq_on & ctrl_o.counter_mode_select;

  // Low time of the interrupt pin, so the pulse length can be judged
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !wave_irq_output.oe)
      low_cnt_r <= 32'h0;
    else
      low_cnt_r <= low_cnt_r + 32'h1;
  end

  a_sda_never_high: assert property (sda_od.o == 1'b0)
    else $error("sda driven high");
  a_irq_never_high: assert property (wave_irq_output.o == 1'b0)
    else $error("interrupt pin driven high");
  a_sda_moves_low: assert property ($changed(sda_od.oe) |-> !bus_in.scl)
    else $error("sda changed while scl high");
  a_ack_held_high: assert property ($rose(bus_in.scl) && sda_od.oe |-> sda_od.oe [*8])
    else $error("sda low not held through scl high");
  // The event waits up to one oscillator period, then crosses two stages and a register
  a_zero_sets_irq: assert property ($rose(counter_zero) && irq_on |-> ##[1:24] wave_irq_output.oe)
    else $error("zero event gave no interrupt");
  a_route_off_quiet: assert property (!ctrl_o.irq_route_select && !$past(ctrl_o.irq_route_select)
    |-> !wave_irq_output.oe)
    else $error("interrupt pin low in square wave mode");
  a_alarm_held_bus: assert property ($fell(wave_irq_output.oe)
    && $past(irq_on && !ctrl_o.counter_mode_select) |-> !bus_in.scl)
    else $error("alarm level dropped without a bus write");
  a_pulse_full: assert property ($fell(wave_irq_output.oe) && $past(wdog)
    |-> low_cnt_r == IRQ_PULSE_CYCLES)
    else $error("watchdog pulse length wrong");
  a_pulse_bounded: assert property (wave_irq_output.oe && wdog
    |-> low_cnt_r < IRQ_PULSE_CYCLES)
    else $error("watchdog pulse too long");

  c_pulse_done: cover property ($fell(wave_irq_output.oe) && $past(wdog));
  c_ack_seen: cover property ($rose(bus_in.scl) && sda_od.oe);
  c_alarm_level: cover property ($rose(wave_irq_output.oe) && !ctrl_o.counter_mode_select);
endmodule

bind sss_top sss_chk #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) sss_chk_i (
  .clk_sys(clk_sys), .rstn(rstn), .counter_zero(counter_zero), .bus_in(bus_in),
  .sda_od(sda_od), .wave_irq_output(wave_irq_output), .ctrl_o(ctrl_o));
`default_nettype wire

// ### sss_i2c_mstr.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bus master model: drives SCL and SDA, released level is high
// ------------------------------------------------------------
module sss_i2c_mstr (
  input  wire logic clk_sys,
  input  wire logic sda_in,
  output var logic  scl,
  output var logic  sda
);
  int hp = 20; // Half bit time in clk_sys cycles, slow or fast rate

  // Idle bus: both lines released
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Wait, then move just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Start or repeated start
  task automatic start();
    tick(2);
    sda = 1'b1;
    tick(hp);
    scl = 1'b1;
    tick(hp);
    sda = 1'b0;
    tick(hp);
    scl = 1'b0;
  endtask

  // Stop; SCL then stands high outside frames
  task automatic stop();
    tick(2);
    sda = 1'b0;
    tick(hp);
    scl = 1'b1;
    tick(hp);
    sda = 1'b1;
    tick(hp);
  endtask

  // One bit out; a gap after SCL falls keeps SDA off the edge
  task automatic bit_out(input logic b);
    tick(2);
    sda = b;
    tick(hp);
    scl = 1'b1;
    tick(hp);
    scl = 1'b0;
  endtask

  // One bit in, sampled in mid high time
  task automatic bit_in(output logic b);
    tick(2);
    sda = 1'b1;
    tick(hp);
    scl = 1'b1;
    tick(hp / 2);
    b = sda_in;
    tick(hp - hp / 2);
    scl = 1'b0;
  endtask

  // Byte out MSB first, then the receiver's acknowledge
  task automatic send(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_out(v[i]);
    bit_in(a);
    ack = ~a;
  endtask

  // Byte in; no acknowledge on the last byte of a read
  task automatic recv(output logic [7:0] v, input logic ack);
    for (int i = 7; i >= 0; i--)
      bit_in(v[i]);
    bit_out(~ack);
  endtask
endmodule
`default_nettype wire

// ### sss_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Testbench: register traffic over the serial bus
// ------------------------------------------------------------
module sss_top_tb;
  localparam int PULSE = 4000;
  localparam int LIMIT = 90000;
  logic                 clk_sys;
  logic                 rstn;
  logic                 osc_clk;
  logic                 osc_rstn;
  logic                 counter_zero;
  logic                 scl_m;
  logic                 sda_m;
  logic                 ack;
  sss_pkg::sss_bus_in_t bus_in;
  sss_pkg::sss_od_t     sda_od;
  sss_pkg::sss_od_t     irq;
  sss_pkg::sss_ctrl_t   ctrl_o;
  logic [7:0]           got [0:3];
  logic [7:0]           wd [0:4];
  int                   bad_count;
  int                   comparisons;
  int                   cycles;

  // Open-drain wire with pull-up: low if either side pulls
  assign bus_in = {scl_m, sda_m & ~sda_od.oe};

  sss_top #(.IRQ_PULSE_CYCLES(PULSE), .OSC_STALL_CYCLES(64)) sss_top_i (
    .clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .osc_clk(osc_clk), .osc_rstn(osc_rstn),
    .counter_zero(counter_zero), .bus_in(bus_in), .sda_od(sda_od),
    .wave_irq_output(irq), .ctrl_o(ctrl_o));
  sss_i2c_mstr sss_i2c_mstr_i (
    .clk_sys(clk_sys), .sda_in(bus_in.sda), .scl(scl_m), .sda(sda_m));

  // System clock and an unrelated oscillator clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    osc_clk = 1'b0;
    #7;
    forever #32 osc_clk = ~osc_clk;
  end

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Address for write, then the pointer byte
  task automatic set_ptr(input logic [7:0] ptr);
    sss_i2c_mstr_i.start();
    sss_i2c_mstr_i.send({sss_pkg::DEV_ADDR, 1'b0}, ack);
    chk({7'h0, ack}, 8'h01);
    sss_i2c_mstr_i.send(ptr, ack);
    chk({7'h0, ack}, 8'h01);
  endtask

  task automatic wr(input logic [7:0] ptr, input int n);
    set_ptr(ptr);
    for (int i = 0; i < n; i++)
    begin
      sss_i2c_mstr_i.send(wd[i], ack);
      chk({7'h0, ack}, 8'h01);
    end
    sss_i2c_mstr_i.stop();
  endtask

  task automatic wr1(input logic [7:0] ptr, input logic [7:0] v);
    wd[0] = v;
    wr(ptr, 1);
  endtask

  // Read n bytes; setp puts a pointer write and repeated start first
  task automatic rd(input logic setp, input logic [7:0] ptr, input int n);
    if (setp)
      set_ptr(ptr);
    sss_i2c_mstr_i.start();
    sss_i2c_mstr_i.send({sss_pkg::DEV_ADDR, 1'b1}, ack);
    chk({7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++)
      sss_i2c_mstr_i.recv(got[i], i < n - 1);
    sss_i2c_mstr_i.stop();
  endtask

  task automatic stat(input logic [7:0] exp);
    rd(1'b1, sss_pkg::OFS_STATUS, 1);
    chk(got[0], exp);
  endtask

  // One oscillator cycle of the zero event, then let it cross
  task automatic zero();
    @(posedge osc_clk);
    #1 counter_zero = 1'b1;
    @(posedge osc_clk);
    #1 counter_zero = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    osc_rstn = 1'b0;
    counter_zero = 1'b0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (30) @(posedge clk_sys);
    #1 osc_rstn = 1'b1;
    chk(ctrl_o, sss_pkg::CTRL_RESET);
    // Fast rate, then slow rate with a foreign address
    sss_i2c_mstr_i.hp = 8;
    stat(8'h80);
    sss_i2c_mstr_i.hp = 60;
    sss_i2c_mstr_i.start();
    sss_i2c_mstr_i.send(8'ha0, ack);
    chk({7'h0, ack}, 8'h00);
    sss_i2c_mstr_i.send(8'h00, ack);
    chk({7'h0, ack}, 8'h00);
    sss_i2c_mstr_i.stop();
    sss_i2c_mstr_i.hp = 20;
    // Burst write, burst read, then a read from the retained pointer
    wd = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    wr(8'h00, 5);
    rd(1'b1, 8'h00, 4);
    for (int i = 0; i < 4; i++)
      chk(got[i], wd[i]);
    rd(1'b0, 8'h00, 1);
    chk(got[0], 8'h55);
    // Oscillator stop flag: clear, then set by disabling
    wr1(sss_pkg::OFS_STATUS, 8'h7e);
    stat(8'h00);
    wr1(sss_pkg::OFS_CONTROL, 8'h80);
    stat(8'h80);
    // Alarm mode: level interrupt held until a zero is written
    wr1(sss_pkg::OFS_CONTROL, 8'h49);
    chk(ctrl_o, 8'h49);
    wr1(sss_pkg::OFS_STATUS, 8'h00);
    zero();
    chk({7'h0, irq.oe}, 8'h01);
    stat(8'h01);
    wr1(sss_pkg::OFS_STATUS, 8'h01);
    stat(8'h01);
    chk({7'h0, irq.oe}, 8'h01);
    wr1(sss_pkg::OFS_STATUS, 8'h00);
    chk({7'h0, irq.oe}, 8'h00);
    // Watchdog mode: fixed pulse that a clear cannot shorten
    wr1(sss_pkg::OFS_CONTROL, 8'h69);
    zero();
    chk({7'h0, irq.oe}, 8'h01);
    wr1(sss_pkg::OFS_STATUS, 8'h00);
    chk({7'h0, irq.oe}, 8'h01);
    for (int i = 0; i < PULSE && irq.oe === 1'b1; i++)
      @(posedge clk_sys);
    #1;
    chk({7'h0, irq.oe}, 8'h00);
    stat(8'h00);
    // Second pulse left alone: only its own end may clear the flag
    zero();
    stat(8'h01);
    for (int i = 0; i < PULSE && irq.oe === 1'b1; i++)
      @(posedge clk_sys);
    #1;
    chk({7'h0, irq.oe}, 8'h00);
    stat(8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
